// [src/drive_status_word_packer.sv]
// drive status word assembly, reference and actual value scaling
`timescale 1ns/1ps

// Summary of operation
// - low sixteen status bits go out unchanged
// - upper status bits never reach fieldbus
// - bit 0 shows ready for start
// - bit 1 follows external run enable
// - bit 3 shows power stage modulating
// - bit 4 shows zero speed
// - bits 5 and 6 show rising, falling
// - bit 7 shows setpoint reached
// - bit 8 shows a limit acting
// - bit 9 shows supervised value above limit
// - bit 10 shows reverse reference direction
// - bit 11 shows motor running reverse
// - bit 12 shows keypad or tool local
// - bit 13 shows fieldbus local control
// - bit 14 shows second remote source selected
// - bit 15 shows a fault present
// - bits 22 to 25 carry user bits
// - bit 26 shows control claimed here
// - references are sign plus 15-bit magnitude
// - actuals are sign plus 15-bit magnitude too, two's complement
// - per-value type selects scaling definition
module drive_status_word_packer (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire status_pack_pkg::drive_cond_t cond_in,
    input wire status_pack_pkg::ref_pair_t ref_in,
    input wire status_pack_pkg::feedback_pair_t act_in,
    input wire status_pack_pkg::scale_sel_t ref_one_type_in,
    input wire status_pack_pkg::scale_sel_t ref_two_type_in,
    input wire status_pack_pkg::scale_sel_t act_one_type_in,
    input wire status_pack_pkg::scale_sel_t act_two_type_in,
    input wire status_pack_pkg::scale_table_t scale_table_in,
    output logic [status_pack_pkg::STATUS_W-1:0] profile_status_word_out,
    output logic [status_pack_pkg::FB_W-1:0] fieldbus_status_out,
    output status_pack_pkg::ref_pair_t ref_scaled_out,
    output status_pack_pkg::feedback_pair_t feedback_out
);

    // ========================================
    // state
    typedef struct packed {
        logic [status_pack_pkg::STATUS_W-1:0] status;
        logic [status_pack_pkg::FB_W-1:0] fb_status;
        status_pack_pkg::ref_pair_t refs;
        status_pack_pkg::feedback_pair_t acts;
    } state_t;

    state_t state_q;
    state_t state_d;

    logic signed [status_pack_pkg::VAL_W-1:0] ref_one_fixed;
    logic signed [status_pack_pkg::VAL_W-1:0] ref_two_fixed;
    logic signed [status_pack_pkg::VAL_W-1:0] ref_one_scaled;
    logic signed [status_pack_pkg::VAL_W-1:0] ref_two_scaled;
    logic signed [status_pack_pkg::VAL_W-1:0] act_one_fixed;
    logic signed [status_pack_pkg::VAL_W-1:0] act_two_fixed;
    logic signed [status_pack_pkg::VAL_W-1:0] act_one_scaled;
    logic signed [status_pack_pkg::VAL_W-1:0] act_two_scaled;

    // ========================================
    // helpers
    // the full negative code has no positive twin in sign plus 15-bit
    // magnitude form, so it is folded onto the most negative legal value
    function automatic logic signed [status_pack_pkg::VAL_W-1:0] fold_value(
        input logic signed [status_pack_pkg::VAL_W-1:0] v
    );
        if (v == status_pack_pkg::VAL_NEG_FULL) begin
            return status_pack_pkg::VAL_MIN;
        end
        return v;
    endfunction

    function automatic logic [status_pack_pkg::STATUS_W-1:0] pack_status(
        input status_pack_pkg::drive_cond_t c
    );
        logic [status_pack_pkg::STATUS_W-1:0] w;
        w = status_pack_pkg::STATUS_RESET;
        w[status_pack_pkg::POS_READY] = c.ready;
        w[status_pack_pkg::POS_RUN_ENABLE] = c.run_enable;
        w[status_pack_pkg::POS_MODULATING] = c.modulating;
        w[status_pack_pkg::POS_ZERO_SPEED] = c.zero_speed;
        w[status_pack_pkg::POS_SPEED_RISING] = c.speed_rising;
        w[status_pack_pkg::POS_SPEED_FALLING] = c.speed_falling;
        w[status_pack_pkg::POS_ON_TARGET] = c.on_target;
        w[status_pack_pkg::POS_LIMITED] = c.limited;
        w[status_pack_pkg::POS_SUPERVISION] = c.supervision_exceeded;
        w[status_pack_pkg::POS_REVERSE_REF] = c.reverse_ref;
        w[status_pack_pkg::POS_REVERSE_ACT] = c.reverse_act;
        w[status_pack_pkg::POS_PANEL_LOCAL] = c.panel_local;
        w[status_pack_pkg::POS_FIELDBUS_LOCAL] = c.fieldbus_local;
        w[status_pack_pkg::POS_SECOND_REMOTE] = c.second_remote_source_selected;
        w[status_pack_pkg::POS_FAULT] = c.fault;
        w[status_pack_pkg::POS_ALARM] = c.alarm;
        w[status_pack_pkg::POS_USER_LO +: status_pack_pkg::USER_BITS] = c.user_bits;
        w[status_pack_pkg::POS_CONTROL_CLAIMED] = c.control_claimed;
        // belt and braces: reserved positions can never leak a one
        return w & ~status_pack_pkg::RESERVED_MASK;
    endfunction

    // ========================================
    // reference and actual value scaling
    assign ref_one_fixed = fold_value(ref_in.ref_one);
    assign ref_two_fixed = fold_value(ref_in.ref_two);
    assign act_one_fixed = fold_value(act_in.feedback_value_one);
    assign act_two_fixed = fold_value(act_in.feedback_value_two);

    scale_select_unit ref_one_scale (
        .value_in(ref_one_fixed),
        .sel_in(ref_one_type_in),
        .table_in(scale_table_in),
        .value_out(ref_one_scaled)
    );

    scale_select_unit ref_two_scale (
        .value_in(ref_two_fixed),
        .sel_in(ref_two_type_in),
        .table_in(scale_table_in),
        .value_out(ref_two_scaled)
    );

    scale_select_unit act_one_scale (
        .value_in(act_one_fixed),
        .sel_in(act_one_type_in),
        .table_in(scale_table_in),
        .value_out(act_one_scaled)
    );

    scale_select_unit act_two_scale (
        .value_in(act_two_fixed),
        .sel_in(act_two_type_in),
        .table_in(scale_table_in),
        .value_out(act_two_scaled)
    );

    // ========================================
    // next state
    always_comb begin
        state_d = state_q;
        state_d.status = pack_status(cond_in);
        // only the low half goes to the fieldbus; the upper half leaves only on profile_status_word_out
        state_d.fb_status = state_d.status[status_pack_pkg::FB_W-1:0];
        state_d.refs.ref_one = ref_one_scaled;
        state_d.refs.ref_two = ref_two_scaled;
        state_d.acts.feedback_value_one = act_one_scaled;
        state_d.acts.feedback_value_two = act_two_scaled;
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state_q.status <= status_pack_pkg::STATUS_RESET;
            state_q.fb_status <= status_pack_pkg::STATUS_RESET[status_pack_pkg::FB_W-1:0];
            state_q.refs.ref_one <= status_pack_pkg::VAL_RESET;
            state_q.refs.ref_two <= status_pack_pkg::VAL_RESET;
            state_q.acts.feedback_value_one <= status_pack_pkg::VAL_RESET;
            state_q.acts.feedback_value_two <= status_pack_pkg::VAL_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ========================================
    // outputs
    assign profile_status_word_out = state_q.status;
    assign fieldbus_status_out = state_q.fb_status;
    assign ref_scaled_out = state_q.refs;
    assign feedback_out = state_q.acts;

    // ========================================
    // checks
    // unity factor: under it a legal value must pass through untouched
    localparam logic [status_pack_pkg::SCALE_W-1:0] UNITY =
        {{(status_pack_pkg::SCALE_W-1){1'b0}}, 1'b1} << status_pack_pkg::SCALE_SHIFT;

    a_low_half_copy: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        fieldbus_status_out == profile_status_word_out[status_pack_pkg::FB_W-1:0])
        else $error("fieldbus status differs from low half of status word");

    a_upper_not_sent: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        $changed(profile_status_word_out[status_pack_pkg::STATUS_W-1:status_pack_pkg::FB_W])
        && $stable(profile_status_word_out[status_pack_pkg::FB_W-1:0])
        |-> $stable(fieldbus_status_out))
        else $error("upper status change reached fieldbus status");

    a_ready_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |-> fieldbus_status_out[status_pack_pkg::POS_READY]
        == $past(cond_in.ready))
        else $error("ready bit does not follow ready condition");

    a_run_enable_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        $rose(cond_in.run_enable) |=> fieldbus_status_out[status_pack_pkg::POS_RUN_ENABLE])
        else $error("run enable bit not set after input rose");

    a_run_disable_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        $fell(cond_in.run_enable) |=> !fieldbus_status_out[status_pack_pkg::POS_RUN_ENABLE])
        else $error("run enable bit not cleared after input fell");

    a_modulating_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        cond_in.modulating [*2] |=> fieldbus_status_out[status_pack_pkg::POS_MODULATING]
        && $past(fieldbus_status_out[status_pack_pkg::POS_MODULATING]))
        else $error("modulating bit not held while modulating");

    a_zero_speed_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |-> fieldbus_status_out[status_pack_pkg::POS_ZERO_SPEED]
        == $past(cond_in.zero_speed))
        else $error("zero speed bit wrong");

    a_speed_trend_bits: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |->
        fieldbus_status_out[status_pack_pkg::POS_SPEED_FALLING:status_pack_pkg::POS_SPEED_RISING]
        == {$past(cond_in.speed_falling), $past(cond_in.speed_rising)})
        else $error("speed rising or falling bit wrong");

    a_on_target_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !cond_in.on_target |=> !fieldbus_status_out[status_pack_pkg::POS_ON_TARGET])
        else $error("setpoint bit set while not on target");

    a_limited_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        cond_in.limited |=> fieldbus_status_out[status_pack_pkg::POS_LIMITED])
        else $error("limit bit clear while limited");

    a_supervision_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |-> fieldbus_status_out[status_pack_pkg::POS_SUPERVISION]
        == $past(cond_in.supervision_exceeded))
        else $error("supervision bit wrong");

    a_reverse_ref_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |-> fieldbus_status_out[status_pack_pkg::POS_REVERSE_REF]
        == $past(cond_in.reverse_ref))
        else $error("reverse reference bit wrong");

    a_reverse_act_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |-> fieldbus_status_out[status_pack_pkg::POS_REVERSE_ACT]
        == $past(cond_in.reverse_act))
        else $error("reverse running bit wrong");

    a_panel_local_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |-> fieldbus_status_out[status_pack_pkg::POS_PANEL_LOCAL]
        == $past(cond_in.panel_local))
        else $error("panel local bit wrong");

    a_fieldbus_local_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |-> fieldbus_status_out[status_pack_pkg::POS_FIELDBUS_LOCAL]
        == $past(cond_in.fieldbus_local))
        else $error("fieldbus local bit wrong");

    a_remote_source_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |-> fieldbus_status_out[status_pack_pkg::POS_SECOND_REMOTE]
        == $past(cond_in.second_remote_source_selected))
        else $error("remote source bit wrong");

    a_fault_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        $rose(cond_in.fault) |=> $rose(fieldbus_status_out[status_pack_pkg::POS_FAULT]))
        else $error("fault bit did not rise one cycle after fault");

    a_user_bits: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |->
        profile_status_word_out[status_pack_pkg::POS_USER_LO +: status_pack_pkg::USER_BITS]
        == $past(cond_in.user_bits))
        else $error("user bits wrong");

    a_control_claim_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !sys_rst_in ##1 1 |-> profile_status_word_out[status_pack_pkg::POS_CONTROL_CLAIMED]
        == $past(cond_in.control_claimed))
        else $error("control claimed bit wrong");

    a_ref_range: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ref_scaled_out.ref_one != status_pack_pkg::VAL_NEG_FULL
        && ref_scaled_out.ref_two != status_pack_pkg::VAL_NEG_FULL)
        else $error("reference left sign plus 15-bit range");

    a_act_range: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        feedback_out.feedback_value_one != status_pack_pkg::VAL_NEG_FULL
        && feedback_out.feedback_value_two != status_pack_pkg::VAL_NEG_FULL)
        else $error("actual value left sign plus 15-bit range");

    a_ref_sign_kept: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ref_in.ref_one < 0 && scale_table_in[ref_one_type_in] != 0
        |=> ref_scaled_out.ref_one <= 0)
        else $error("negative reference turned positive");

    a_scale_select: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        scale_table_in[ref_two_type_in] == 0 |=> ref_scaled_out.ref_two == 0)
        else $error("reference two ignored its selected scaling");

    a_reserved_zero: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (profile_status_word_out & status_pack_pkg::RESERVED_MASK) == 0)
        else $error("reserved status bit set");

    a_modulating_stop: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !cond_in.modulating |=> !fieldbus_status_out[status_pack_pkg::POS_MODULATING])
        else $error("modulating bit set while stopped");

    a_on_target_set: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        cond_in.on_target |=> fieldbus_status_out[status_pack_pkg::POS_ON_TARGET])
        else $error("setpoint bit clear while on target");

    a_limit_released: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !cond_in.limited |=> !fieldbus_status_out[status_pack_pkg::POS_LIMITED])
        else $error("limit bit set while no limit acts");

    a_run_enable_held: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        cond_in.run_enable |=> fieldbus_status_out[status_pack_pkg::POS_RUN_ENABLE])
        else $error("run enable bit clear while input active");

    a_fault_held: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        cond_in.fault |=> profile_status_word_out[status_pack_pkg::POS_FAULT])
        else $error("fault bit clear while fault present");

    a_fault_clear: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        $fell(cond_in.fault) |=> !fieldbus_status_out[status_pack_pkg::POS_FAULT])
        else $error("fault bit not cleared after fault went");

    a_ref_one_unity: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        scale_table_in[ref_one_type_in] == UNITY
        && ref_in.ref_one != status_pack_pkg::VAL_NEG_FULL
        |=> ref_scaled_out.ref_one == $past(ref_in.ref_one))
        else $error("reference one changed under unity scaling");

    a_act_one_unity: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        scale_table_in[act_one_type_in] == UNITY
        && act_in.feedback_value_one != status_pack_pkg::VAL_NEG_FULL
        |=> feedback_out.feedback_value_one == $past(act_in.feedback_value_one))
        else $error("actual value one changed under unity scaling");

    a_act_fold: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        act_in.feedback_value_two == status_pack_pkg::VAL_NEG_FULL
        && scale_table_in[act_two_type_in] == UNITY
        |=> feedback_out.feedback_value_two == status_pack_pkg::VAL_MIN)
        else $error("actual value two not folded to -32767");

    a_ref_two_sign: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ref_in.ref_two < 0 && scale_table_in[ref_two_type_in] != 0
        |=> ref_scaled_out.ref_two <= 0)
        else $error("negative reference two turned positive");

    a_act_two_sign: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        act_in.feedback_value_two < 0 && scale_table_in[act_two_type_in] != 0
        |=> feedback_out.feedback_value_two <= 0)
        else $error("negative actual value two turned positive");

    a_act_zero_scale: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        scale_table_in[act_one_type_in] == 0 |=> feedback_out.feedback_value_one == 0)
        else $error("actual value one ignored its selected scaling");

endmodule

// [src/status_pack_pkg.sv]
// shared constants and types for the drive status word packer
package status_pack_pkg;

    // ========================================
    // widths
    localparam int STATUS_W = 32;
    localparam int FB_W = 16;
    localparam int VAL_W = 16;
    localparam int SCALE_W = 16;
    localparam int TYPE_W = 2;
    localparam int SCALE_DEFS = 4;
    localparam int USER_BITS = 4;
    // unity scale factor is 2**SCALE_SHIFT
    localparam int SCALE_SHIFT = 14;

    // ========================================
    // status word bit positions
    localparam int POS_READY = 0;
    localparam int POS_RUN_ENABLE = 1;
    localparam int POS_MODULATING = 3;
    localparam int POS_ZERO_SPEED = 4;
    localparam int POS_SPEED_RISING = 5;
    localparam int POS_SPEED_FALLING = 6;
    localparam int POS_ON_TARGET = 7;
    localparam int POS_LIMITED = 8;
    localparam int POS_SUPERVISION = 9;
    localparam int POS_REVERSE_REF = 10;
    localparam int POS_REVERSE_ACT = 11;
    localparam int POS_PANEL_LOCAL = 12;
    localparam int POS_FIELDBUS_LOCAL = 13;
    localparam int POS_SECOND_REMOTE = 14;
    localparam int POS_FAULT = 15;
    localparam int POS_ALARM = 16;
    localparam int POS_USER_LO = 22;
    localparam int POS_CONTROL_CLAIMED = 26;

    // ========================================
    // reset values and masks
    localparam logic [STATUS_W-1:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [STATUS_W-1:0] RESERVED_MASK = 32'hF83E_0004;
    localparam logic signed [VAL_W-1:0] VAL_RESET = 16'sh0000;
    localparam logic signed [VAL_W-1:0] VAL_MAX = 16'sh7FFF;
    localparam logic signed [VAL_W-1:0] VAL_MIN = 16'sh8001;
    localparam logic signed [VAL_W-1:0] VAL_NEG_FULL = 16'sh8000;

    // ========================================
    // types
    typedef struct packed {
        logic ready;
        logic run_enable;
        logic modulating;
        logic zero_speed;
        logic speed_rising;
        logic speed_falling;
        logic on_target;
        logic limited;
        logic supervision_exceeded;
        logic reverse_ref;
        logic reverse_act;
        logic panel_local;
        logic fieldbus_local;
        logic second_remote_source_selected;
        logic fault;
        logic alarm;
        logic [USER_BITS-1:0] user_bits;
        logic control_claimed;
    } drive_cond_t;

    typedef logic [TYPE_W-1:0] scale_sel_t;
    typedef logic [SCALE_DEFS-1:0][SCALE_W-1:0] scale_table_t;

    typedef struct packed {
        logic signed [VAL_W-1:0] ref_one;
        logic signed [VAL_W-1:0] ref_two;
    } ref_pair_t;

    typedef struct packed {
        logic signed [VAL_W-1:0] feedback_value_one;
        logic signed [VAL_W-1:0] feedback_value_two;
    } feedback_pair_t;

endpackage

// [src/scale_select_unit.sv]
// selects one scaling definition and scales a signed 16-bit value
`timescale 1ns/1ps
module scale_select_unit (
    input wire logic signed [status_pack_pkg::VAL_W-1:0] value_in,
    input wire status_pack_pkg::scale_sel_t sel_in,
    input wire status_pack_pkg::scale_table_t table_in,
    output logic signed [status_pack_pkg::VAL_W-1:0] value_out
);
    localparam int PROD_W = status_pack_pkg::VAL_W + status_pack_pkg::SCALE_W + 1;
    localparam logic signed [PROD_W-1:0] MAX_WIDE = PROD_W'(status_pack_pkg::VAL_MAX);
    localparam logic signed [PROD_W-1:0] MIN_WIDE = PROD_W'(status_pack_pkg::VAL_MIN);

    logic signed [status_pack_pkg::SCALE_W:0] factor;
    logic signed [PROD_W-1:0] product;
    logic signed [PROD_W-1:0] shifted;

    // ========================================
    // scaling
    always_comb begin
        // factor is unsigned in the table, widened so the multiply stays signed
        factor = $signed({1'b0, table_in[sel_in]});
        product = PROD_W'(value_in) * PROD_W'(factor);
        shifted = product >>> status_pack_pkg::SCALE_SHIFT;
        // saturate to the 15-bit magnitude range; -32768 is never produced
        if (shifted > MAX_WIDE) begin
            value_out = status_pack_pkg::VAL_MAX;
        end else if (shifted < MIN_WIDE) begin
            value_out = status_pack_pkg::VAL_MIN;
        end else begin
            value_out = shifted[status_pack_pkg::VAL_W-1:0];
        end
    end
endmodule

// [test/fieldbus_master_model.sv]
// behavioural fieldbus master that forms the two signed references
`timescale 1ns/1ps
module fieldbus_master_model (
    input wire logic [14:0] mag_in,
    input wire logic neg_in,
    output status_pack_pkg::ref_pair_t ref_out
);
    // ========================================
    // reference encoding
    logic signed [15:0] word_v;

    // the magnitude is only 15 bits wide, so the master can never send the unpaired 0x8000
    assign word_v = {1'b0, mag_in};
    assign ref_out.ref_one = neg_in ? -word_v : word_v;
    assign ref_out.ref_two = neg_in ? -word_v : word_v;
endmodule

// [test/drive_status_word_packer_test.sv]
// self-checking bench for the drive status word packer
`timescale 1ns/1ps
module drive_status_word_packer_test;
    // ========================================
    // stimulus and observed signals
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    status_pack_pkg::drive_cond_t cond = '1;
    status_pack_pkg::feedback_pair_t act = '0;
    status_pack_pkg::scale_sel_t type_sel = '0;
    status_pack_pkg::scale_sel_t ref_two_sel = '0;
    status_pack_pkg::scale_sel_t act_one_sel = '0;
    status_pack_pkg::scale_sel_t act_two_sel = '0;
    // entries 3..0: zero, double, half, unity
    status_pack_pkg::scale_table_t table_v = {16'h0000, 16'h8000, 16'h2000, 16'h4000};
    logic [14:0] mag = '0;
    logic neg = 1'b0;
    status_pack_pkg::ref_pair_t ref_v;
    logic [31:0] word;
    logic [31:0] bit_v;
    logic [15:0] fb;
    status_pack_pkg::ref_pair_t ref_scaled;
    status_pack_pkg::feedback_pair_t fdbk;
    int fails = 0;
    int checks_done = 0;

    // status bit for each condition, walking from the struct's top bit down
    localparam int POS [21] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16,
                               25, 24, 23, 22, 26};
    localparam logic [14:0] MAGS [8] = '{15'h03E8, 15'h03E8, 15'h03E9, 15'h03E9,
                                        15'h4E20, 15'h4E20, 15'h7FFF, 15'h7FFF};
    localparam logic NEGS [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    localparam logic [1:0] TYPES [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
    // halving rounds toward minus infinity, doubling saturates symmetrically
    localparam logic [15:0] EXPS [8] = '{16'h03E8, 16'hFC18, 16'h01F4, 16'hFE0B,
                                        16'h7FFF, 16'h8001, 16'h0000, 16'h8001};

    always #2.5 core_clk_in = ~core_clk_in;

    // ========================================
    // instances
    fieldbus_master_model i_fieldbus_master_model (
        .mag_in(mag),
        .neg_in(neg),
        .ref_out(ref_v)
    );

    drive_status_word_packer i_drive_status_word_packer (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .cond_in(cond),
        .ref_in(ref_v),
        .act_in(act),
        .ref_one_type_in(type_sel),
        .ref_two_type_in(ref_two_sel),
        .act_one_type_in(act_one_sel),
        .act_two_type_in(act_two_sel),
        .scale_table_in(table_v),
        .profile_status_word_out(word),
        .fieldbus_status_out(fb),
        .ref_scaled_out(ref_scaled),
        .feedback_out(fdbk)
    );

    // ========================================
    // compare and closing tasks
    task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic compare_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ========================================
    // tests
    initial begin
        // every condition is active during reset, so a clear word proves reset wins
        repeat (20) @(negedge core_clk_in);
        compare_word(word, 32'h0000_0000);
        compare_word({16'h0000, fb}, 32'h0000_0000);
        sys_rst_in = 1'b0;
        @(negedge core_clk_in);
        compare_word(word, 32'h07C1_FFFB);
        compare_word({16'h0000, fb}, 32'h0000_FFFB);
        for (int k = 0; k < 21; k++) begin
            cond = 21'(1) << (20 - k);
            bit_v = 32'h1 << POS[k];
            @(negedge core_clk_in);
            compare_word(word, bit_v);
            compare_word({16'h0000, fb}, bit_v & 32'h0000_FFFF);
        end
        cond = '0;
        @(negedge core_clk_in);
        compare_word(word, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            mag = MAGS[i];
            neg = NEGS[i];
            type_sel = TYPES[i];
            ref_two_sel = TYPES[i];
            act_one_sel = TYPES[i];
            act_two_sel = TYPES[i];
            act = {2{(NEGS[i] ? 16'h0000 - {1'b0, MAGS[i]} : {1'b0, MAGS[i]})}};
            @(negedge core_clk_in);
            compare_val(ref_scaled.ref_one, EXPS[i]);
            compare_val(ref_scaled.ref_two, EXPS[i]);
            compare_val(fdbk.feedback_value_one, EXPS[i]);
            compare_val(fdbk.feedback_value_two, EXPS[i]);
        end
        // all values stand at 0x8001 here, so cleared outputs prove reset wins mid-run
        sys_rst_in = 1'b1;
        cond = '1;
        @(negedge core_clk_in);
        compare_word(word, 32'h0000_0000);
        compare_val(ref_scaled.ref_two, 16'h0000);
        compare_val(fdbk.feedback_value_one, 16'h0000);
        sys_rst_in = 1'b0;
        // each value picks its own scaling: unity, half, double, zero
        mag = 15'h03E8;
        neg = 1'b0;
        type_sel = 2'h0;
        ref_two_sel = 2'h1;
        act_one_sel = 2'h2;
        act_two_sel = 2'h3;
        act = {2{16'h03E8}};
        @(negedge core_clk_in);
        compare_word(word, 32'h07C1_FFFB);
        compare_val(ref_scaled.ref_one, 16'h03E8);
        compare_val(ref_scaled.ref_two, 16'h01F4);
        compare_val(fdbk.feedback_value_one, 16'h07D0);
        compare_val(fdbk.feedback_value_two, 16'h0000);
        // a raw 0x8000 has no positive partner and must come back as -32767
        type_sel = 2'h0;
        act_one_sel = 2'h0;
        act_two_sel = 2'h0;
        act = {16'h8000, 16'h8000};
        @(negedge core_clk_in);
        compare_val(fdbk.feedback_value_one, 16'h8001);
        compare_val(fdbk.feedback_value_two, 16'h8001);
        stop_test();
    end

    // ========================================
    // watchdog: the tests need well under 100 cycles
    initial begin
        repeat (2000) @(posedge core_clk_in);
        fails++;
        stop_test();
    end
endmodule
